// ### include/otp_region_defs.vh
// constants for the secure-region serial command block
// assumes inclusion by the design files of that block only
`ifndef OTP_REGION_DEFS_VH
`define OTP_REGION_DEFS_VH

// ==========================================================
// opcodes
`define OP_PROG_REGION   8'h9b
`define OP_READ_REGION   8'h77
`define OP_WRITE_ENABLE  8'h06
`define OP_READ_STATUS   8'h05

// ==========================================================
// region layout
`define REGION_BYTES     128
`define USER_BYTES       64
`define ERASED_BYTE      8'hff

// ==========================================================
// frame counts (bytes after the opcode)
`define ADDR_BYTES       3'h3
`define DUMMY_BYTES      3'h2
`define PROG_DATA_START  3'h4
`define READ_DATA_START  3'h6
`define BIT_LAST         3'h7

// ==========================================================
// timing
`define PROG_TIME_NS     2_000_000
`define CLK_PERIOD_NS    40
`define BUSY_BIT         0

`endif

// ### src/byte_skid_buffer.v
// two-entry valid/ready buffer for bytes entering the page buffer
// assumes one clock; source honours o_in_ready
`timescale 1ns/1ps
module byte_skid_buffer #(
  parameter WIDTH = 14
) (
  // clock and reset
  input  wire             i_clk_sys,
  input  wire             i_reset,
  // fill side
  input  wire             i_in_valid,
  input  wire [WIDTH-1:0] i_in_data,
  output wire             o_in_ready,
  // drain side
  output wire             o_out_valid,
  output wire [WIDTH-1:0] o_out_data,
  input  wire             i_out_ready
);

  reg [WIDTH-1:0] mem_q [0:1];
  reg             wr_ptr_q;
  reg             rd_ptr_q;
  reg [1:0]       count_q;
  wire            push;
  wire            pop;

  assign o_in_ready  = (count_q != 2'h2);
  assign o_out_valid = (count_q != 2'h0);
  assign o_out_data  = mem_q[rd_ptr_q];
  assign push        = i_in_valid & o_in_ready;
  assign pop         = o_out_valid & i_out_ready;

  always @(posedge i_clk_sys) begin
    if (push) begin
      mem_q[wr_ptr_q] <= i_in_data;
    end
  end

  always @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      wr_ptr_q <= 1'b0;
      rd_ptr_q <= 1'b0;
      count_q  <= 2'h0;
    end else begin
      if (push) begin
        wr_ptr_q <= ~wr_ptr_q;
      end
      if (pop) begin
        rd_ptr_q <= ~rd_ptr_q;
      end
      if (push & ~pop) begin
        count_q <= count_q + 2'h1;
      end else if (pop & ~push) begin
        count_q <= count_q - 2'h1;
      end
    end
  end

endmodule

// ### src/otp_region_access.v
// secure-region program and read commands of a serial flash slave
// assumes spi mode 0/3 pins from outside, oversampled by i_clk_sys
`timescale 1ns/1ps
`include "otp_region_defs.vh"

// Behaviour
// RULE_01 - 128-byte region, locations 0..63 user part
// RULE_02 - locations 64..127 fixed serial number
// RULE_03 - user part programs once, then refused
// RULE_04 - host sets write permit before programming
// RULE_05 - program frame: 9Bh, address, data bytes
// RULE_06 - program uses only six address bits
// RULE_07 - buffer pointer wraps past byte 63
// RULE_08 - only last 64 bytes kept
// RULE_09 - program on deselect; untouched bytes stay FFh
// RULE_10 - programming self-timed after chip select rises
// RULE_11 - incomplete or uneven frame aborts programming
// RULE_12 - abort clears write permit latch
// RULE_13 - status reads served, show busy
// RULE_14 - write permit cleared before programming ends
// RULE_15 - host should poll busy flag
// RULE_16 - shared page buffer overwritten by command
// RULE_17 - interrupted programming leaves part locked
// RULE_18 - read frame: 77h, address, two dummies, data
// RULE_19 - read wraps 7Fh to 00h seamlessly
// RULE_20 - deselect ends read, floats output
// RULE_21 - reads up to maximum serial clock rate
// RULE_22 - 06h on byte boundary sets latch
// RULE_23 - 05h streams status, bit0 busy
// RULE_24 - ready_busy_flag one while programming
// RULE_25 - msb first, sample rise, shift fall
// RULE_26 - read uses seven address bits
// RULE_27 - other opcodes ignored while busy
module otp_region_access #(
  parameter PROG_CYCLES = `PROG_TIME_NS / `CLK_PERIOD_NS,
  parameter [511:0] SERIAL_NUMBER = {64{8'h5a}}  // arbitrary value
) (
  // clock and reset
  input  wire       i_clk_sys,
  input  wire       i_reset,
  // serial link pins
  input  wire       i_sck,
  input  wire       i_cs_n,
  input  wire       i_si,
  output reg        o_so,
  output reg        o_so_oe_n,
  // state seen outside
  input  wire       i_power_good,
  output reg        o_ready_busy_flag,
  output reg        o_write_permit_latch,
  output reg        o_user_locked
);

  localparam S_IDLE = 4'b0001;
  localparam S_PROG = 4'b0010;
  localparam S_READ = 4'b0100;
  localparam S_STAT = 4'b1000;

  // ========================================================
  // pin synchronisers
  reg [1:0] sck_s_q;
  reg [1:0] cs_s_q;
  reg [1:0] si_s_q;
  reg [1:0] pg_s_q;
  reg       sck_d1_q;
  reg       cs_d1_q;
  wire      sck_rise = sck_s_q[1] & ~sck_d1_q;
  wire      sck_fall = ~sck_s_q[1] & sck_d1_q;
  wire      cs_rise  = cs_s_q[1] & ~cs_d1_q;
  wire      cs_low   = ~cs_s_q[1];

  always @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      sck_s_q  <= 2'b00;
      cs_s_q   <= 2'b11;
      si_s_q   <= 2'b00;
      pg_s_q   <= 2'b11;
      sck_d1_q <= 1'b0;
      cs_d1_q  <= 1'b1;
    end else begin
      sck_s_q  <= {sck_s_q[0], i_sck};
      cs_s_q   <= {cs_s_q[0], i_cs_n};
      si_s_q   <= {si_s_q[0], i_si};
      pg_s_q   <= {pg_s_q[0], i_power_good};
      sck_d1_q <= sck_s_q[1];
      cs_d1_q  <= cs_s_q[1];
    end
  end

  // ========================================================
  // storage
  reg [7:0] user_mem [0:`USER_BYTES-1];                 // RULE_01
  reg [7:0] page_buf [0:255];                           // RULE_16
  reg [63:0] buf_hit_q;

  // ========================================================
  // frame state
  reg [3:0]  state_q;
  reg [2:0]  bit_cnt_q;
  reg [2:0]  byte_cnt_q;
  reg [7:0]  shift_q;
  reg [6:0]  addr_q;
  reg        data_seen_q;
  reg [7:0]  opcode_q;
  reg        op_valid_q;
  reg [7:0]  out_q;
  reg        out_ld_q;
  reg        prog_arm_q;
  reg        busy_q;
  reg [31:0] prog_cnt_q;
  reg [6:0]  prog_idx_q;
  reg        in_valid_q;
  reg [13:0] in_data_q;
  wire       in_ready;
  wire       buf_valid;
  wire [13:0] buf_data;
  wire [7:0] byte_in = {shift_q[6:0], si_s_q[1]};
  wire       byte_done = sck_rise & (bit_cnt_q == `BIT_LAST);
  wire [7:0] status_byte = {6'h00, o_write_permit_latch, busy_q};
  wire [6:0] rd_next = addr_q + 7'h01;                  // RULE_19
  wire [7:0] rd_byte = addr_q[6] ?
    SERIAL_NUMBER[{addr_q[5:0], 3'b000} +: 8] :         // RULE_02
    user_mem[addr_q[5:0]];

  // bytes reach the page buffer through the skid buffer
  byte_skid_buffer #(
    .WIDTH (14)
  ) u_skid (
    .i_clk_sys   (i_clk_sys),
    .i_reset     (i_reset),
    .i_in_valid  (in_valid_q),
    .i_in_data   (in_data_q),
    .o_in_ready  (in_ready),
    .o_out_valid (buf_valid),
    .o_out_data  (buf_data),
    .i_out_ready (1'b1)
  );

  always @(posedge i_clk_sys) begin
    if (buf_valid) begin
      page_buf[{2'b00, buf_data[13:8]}] <= buf_data[7:0];  // RULE_08
    end
  end

  // ========================================================
  // command decoder and shifter
  always @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      state_q              <= S_IDLE;
      bit_cnt_q            <= 3'h0;
      byte_cnt_q           <= 3'h0;
      shift_q              <= 8'h00;
      addr_q               <= 7'h00;
      data_seen_q          <= 1'b0;
      opcode_q             <= 8'h00;
      op_valid_q           <= 1'b0;
      out_q                <= 8'h00;
      out_ld_q             <= 1'b0;
      prog_arm_q           <= 1'b0;
      o_write_permit_latch <= 1'b0;
      in_valid_q           <= 1'b0;
      in_data_q            <= 14'h0000;
      buf_hit_q            <= 64'h0;
      o_so                 <= 1'b0;
      o_so_oe_n            <= 1'b1;
    end else begin
      prog_arm_q <= 1'b0;
      out_ld_q   <= 1'b0;
      if (in_ready) begin
        in_valid_q <= 1'b0;
      end
      if (cs_rise) begin
        o_so_oe_n <= 1'b1;                              // RULE_20
        if (op_valid_q && bit_cnt_q == 3'h0) begin
          if (opcode_q == `OP_WRITE_ENABLE && !busy_q) begin
            o_write_permit_latch <= 1'b1;               // RULE_22
          end
        end
        if (state_q == S_PROG) begin
          if (data_seen_q && bit_cnt_q == 3'h0 && !o_user_locked) begin
            prog_arm_q <= 1'b1;                         // RULE_09 RULE_11
          end else begin
            o_write_permit_latch <= 1'b0;               // RULE_12
          end
        end
        state_q     <= S_IDLE;
        bit_cnt_q   <= 3'h0;
        byte_cnt_q  <= 3'h0;
        op_valid_q  <= 1'b0;
        data_seen_q <= 1'b0;
      end else if (cs_low && sck_rise) begin            // RULE_25
        bit_cnt_q <= bit_cnt_q + 3'h1;
        shift_q   <= byte_in;
        if (byte_done) begin
          if (!op_valid_q) begin
            op_valid_q <= 1'b1;
            opcode_q   <= byte_in;
            if (byte_in == `OP_READ_STATUS) begin
              state_q <= S_STAT;                        // RULE_13
              out_q   <= status_byte;
              out_ld_q <= 1'b1;
            end else if (busy_q) begin
              state_q <= S_IDLE;                        // RULE_27
              op_valid_q <= 1'b1;
              opcode_q   <= 8'h00;
            end else if (byte_in == `OP_PROG_REGION &&
                         o_write_permit_latch) begin    // RULE_04
              state_q   <= S_PROG;                      // RULE_05
              buf_hit_q <= 64'h0;
            end else if (byte_in == `OP_READ_REGION) begin
              state_q <= S_READ;                        // RULE_18
            end
          end else begin
            if (byte_cnt_q != 3'h7) begin
              byte_cnt_q <= byte_cnt_q + 3'h1;
            end
            if (byte_cnt_q == 3'h2) begin
              addr_q <= byte_in[6:0];                   // RULE_26
            end
            if (state_q == S_PROG) begin
              if (byte_cnt_q == 3'h2) begin
                addr_q <= {1'b0, byte_in[5:0]};         // RULE_06
              end else if (byte_cnt_q >= 3'h3) begin
                data_seen_q <= 1'b1;
                in_valid_q  <= 1'b1;
                in_data_q   <= {addr_q[5:0], byte_in};
                buf_hit_q[addr_q[5:0]] <= 1'b1;
                addr_q <= {1'b0, addr_q[5:0] + 6'h01};  // RULE_07
              end
            end
            if (state_q == S_READ && byte_cnt_q >= 3'h4) begin
              // step past the byte just loaded, else it goes out twice
              out_q    <= rd_byte;
              out_ld_q <= 1'b1;
              addr_q   <= rd_next;
            end
            if (state_q == S_STAT) begin
              out_q    <= status_byte;                  // RULE_23
              out_ld_q <= 1'b1;
            end
          end
        end
      end else if (cs_low && sck_fall && out_ld_q == 1'b0 &&
                   (state_q == S_STAT ||
                    (state_q == S_READ &&
                     byte_cnt_q >= `DUMMY_BYTES + `ADDR_BYTES))) begin
        o_so_oe_n <= 1'b0;                              // RULE_21
        o_so      <= out_q[~bit_cnt_q];
      end
      if (prog_arm_q || (busy_q && prog_cnt_q == 32'h1)) begin
        o_write_permit_latch <= 1'b0;                   // RULE_14
      end
    end
  end

  // ========================================================
  // self-timed programming
  always @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      busy_q            <= 1'b0;
      prog_cnt_q        <= 32'h0;
      prog_idx_q        <= 7'h00;
      o_ready_busy_flag <= 1'b0;
    end else begin
      o_ready_busy_flag <= busy_q | prog_arm_q;         // RULE_24
      if (prog_arm_q) begin
        busy_q     <= 1'b1;                             // RULE_10
        prog_cnt_q <= PROG_CYCLES;
        prog_idx_q <= 7'h00;
      end else if (busy_q) begin
        if (prog_idx_q[6] == 1'b0) begin
          prog_idx_q <= prog_idx_q + 7'h01;
        end
        if (prog_cnt_q <= 32'h1) begin
          busy_q <= 1'b0;
        end else begin
          prog_cnt_q <= prog_cnt_q - 32'h1;
        end
      end
    end
  end

  integer i;
  always @(posedge i_clk_sys) begin
    if (busy_q && !prog_idx_q[6] && buf_hit_q[prog_idx_q[5:0]]) begin
      user_mem[prog_idx_q[5:0]] <= page_buf[{2'b00, prog_idx_q[5:0]}];
    end
  end

  // erased state of the user part at power-up
  initial begin
    for (i = 0; i < `USER_BYTES; i = i + 1) begin
      user_mem[i] = `ERASED_BYTE;                       // RULE_09
    end
  end

  // lock set at arm, so a power loss mid-cycle still locks
  always @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      o_user_locked <= 1'b0;
    end else if (prog_arm_q || (busy_q && !pg_s_q[1])) begin
      o_user_locked <= 1'b1;                            // RULE_03 RULE_17
    end
  end

endmodule

// ### test/spi_host_model.sv
// behavioural host spi controller, mode 0, msb first
// assumes the device oversamples the pins; half period 160 ns
`timescale 1ns/1ps
module spi_host_model (
  // serial pins toward the device
  output reg  o_sck,
  output reg  o_cs_n,
  output reg  o_si,
  // serial data back, already resolved with its pull-up
  input  wire i_so
);
  localparam HALF = 160;

  initial begin
    o_sck  = 1'b0;
    o_cs_n = 1'b1;
    o_si   = 1'b0;
  end

  // ==========================================================
  // framing; sck stands still low outside frames
  task sel;
    begin
      o_cs_n = 1'b0;
      #HALF;
    end
  endtask

  // data line flips on release so a stale bit is never reused
  task desel;
    begin
      #HALF;
      o_cs_n = 1'b1;
      o_si   = ~o_si;
      #(2 * HALF);
    end
  endtask

  // n bits of tx out, n bits back; partial bytes allowed
  task xfer(input integer n, input [7:0] tx, output [7:0] rxb);
    integer k;
    begin
      rxb = 8'h00;
      for (k = 7; k > 7 - n; k = k - 1) begin
        o_si = tx[k];
        #HALF o_sck = 1'b1;
        rxb[k] = i_so;
        #HALF o_sck = 1'b0;
      end
    end
  endtask
endmodule

// ### test/otp_region_checker.sv
// pin-level assertions for the secure-region command block
// assumes bind onto otp_region_access; sck half period >= 4 clocks
`timescale 1ns/1ps
module otp_region_checker #(
  parameter PROG_CYCLES = 50
) (
  // clock and reset
  input wire i_clk_sys,
  input wire i_reset,
  // serial pins
  input wire i_sck,
  input wire i_cs_n,
  input wire i_si,
  input wire o_so,
  input wire o_so_oe_n,
  // state
  input wire i_power_good,
  input wire o_ready_busy_flag,
  input wire o_write_permit_latch,
  input wire o_user_locked
);
  // ==========================================================
  // busy length counter
  reg [31:0] busy_cnt_q;
  always @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) busy_cnt_q <= 32'h0000_0000;
    else if (o_ready_busy_flag) busy_cnt_q <= busy_cnt_q + 32'h0000_0001;
    else busy_cnt_q <= 32'h0000_0000;
  end

  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_reset);

  // ==========================================================
  // properties
  AST_SO_FLOATS: assert property (i_cs_n [*5] |-> o_so_oe_n)
    else $error("serial out driven while deselected");
  AST_BUSY_BOUND: assert property (
    o_ready_busy_flag |-> busy_cnt_q <= PROG_CYCLES + 1)
    else $error("programming ran too long");
  AST_BUSY_AFTER_CS: assert property ($rose(o_ready_busy_flag) |-> i_cs_n)
    else $error("programming started inside a frame");
  AST_LATCH_DONE: assert property (
    $fell(o_ready_busy_flag) |-> !o_write_permit_latch)
    else $error("write permit still set after programming");
  AST_LOCK_STICKY: assert property (!$fell(o_user_locked))
    else $error("user part unlocked again");
  AST_BUSY_LOCKED: assert property (o_ready_busy_flag |-> o_user_locked)
    else $error("programming without lock");
  AST_LATCH_ON_CS: assert property ($rose(o_write_permit_latch) |-> i_cs_n)
    else $error("write permit set inside a frame");
  AST_LATCH_IDLE: assert property (
    $rose(o_write_permit_latch) |-> !o_ready_busy_flag)
    else $error("write permit set while busy");
endmodule

bind otp_region_access otp_region_checker #(.PROG_CYCLES(PROG_CYCLES)) u_chk (
  .i_clk_sys(i_clk_sys), .i_reset(i_reset), .i_sck(i_sck),
  .i_cs_n(i_cs_n), .i_si(i_si), .o_so(o_so), .o_so_oe_n(o_so_oe_n),
  .i_power_good(i_power_good), .o_ready_busy_flag(o_ready_busy_flag),
  .o_write_permit_latch(o_write_permit_latch),
  .o_user_locked(o_user_locked));

// ### test/tb.sv
// self-checking bench for the secure-region command block
// assumes the host model drives the pins; power stays good throughout
`timescale 1ns/1ps
module tb;
  // long enough that status polls catch the busy window
  localparam PROG = 400;
  // arbitrary serial number byte, repeated over the fixed half
  localparam [7:0] SN = 8'hc3;
  reg        clk_sys    = 1'b0;
  reg        reset      = 1'b1;
  reg        power_good = 1'b1;
  wire       sck, cs_n, si, so, so_oe_n, busy, latch, locked;
  integer    mismatches = 0;
  integer    n_tests    = 0;
  integer    cyc        = 0;
  integer    i;
  reg [7:0]  rx, s;
  reg [7:0]  d [0:2];
  reg [7:0]  mem [0:63];
  reg [23:0] a;

  always #20 clk_sys = ~clk_sys;

  otp_region_access #(.PROG_CYCLES(PROG), .SERIAL_NUMBER({64{SN}})) dut (
    .i_clk_sys(clk_sys), .i_reset(reset), .i_sck(sck), .i_cs_n(cs_n),
    .i_si(si), .o_so(so), .o_so_oe_n(so_oe_n), .i_power_good(power_good),
    .o_ready_busy_flag(busy), .o_write_permit_latch(latch),
    .o_user_locked(locked));

  // released line reads high through its pull-up
  spi_host_model host (.o_sck(sck), .o_cs_n(cs_n), .o_si(si),
    .i_so(so_oe_n ? 1'b1 : so));

  // ==========================================================
  // helpers
  task finish_test;
    begin
      if (mismatches == 0 && n_tests > 0) begin
        $display("verification passed");
      end else begin
        $display("verification failed");
      end
      $finish;
    end
  endtask

  task chk(input [7:0] got, input [7:0] exp);
    begin
      n_tests = n_tests + 1;
      if (got !== exp) begin
        mismatches = mismatches + 1;
        $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
    end
  endtask

  function [7:0] exp_byte(input [6:0] ad);
    exp_byte = ad[6] ? SN : mem[ad[5:0]];
  endfunction

  task send(input [7:0] b);
    begin
      host.xfer(8, b, rx);
    end
  endtask

  task hdr(input [7:0] op, input [23:0] ad);
    begin
      host.sel;
      send(op);
      send(ad[23:16]);
      send(ad[15:8]);
      send(ad[7:0]);
    end
  endtask

  task status;
    begin
      host.sel;
      send(8'h05);
      host.xfer(8, 8'h00, s);
      host.desel;
    end
  endtask

  task wen;
    begin
      host.sel;
      send(8'h06);
      host.desel;
    end
  endtask

  // partial last byte, then deselect mid-byte
  task read_chk(input [23:0] ad, input integer n);
    integer k;
    begin
      hdr(8'h77, ad);
      send(8'h00);
      send(8'h00);
      for (k = 0; k < n; k = k + 1) begin
        host.xfer(8, 8'h00, rx);
        chk(rx, exp_byte(ad[6:0] + k[6:0]));
      end
      host.xfer(3, 8'h00, rx);
      host.desel;
    end
  endtask

  always @(posedge clk_sys) begin
    cyc = cyc + 1;
    if (cyc == 40000) begin
      mismatches = mismatches + 1;
      finish_test;
    end
  end

  // ==========================================================
  // main sequence
  initial begin
    for (i = 0; i < 64; i = i + 1) mem[i] = 8'hff;
    rx = $urandom(3);
    repeat (3) @(posedge clk_sys);
    #3 reset = 1'b0;
    repeat (4) @(posedge clk_sys);
    #3 status;
    chk(s, 8'h00);
    read_chk({$urandom, 7'h7e}, 4);
    hdr(8'h9b, $urandom);
    send(8'h12);
    host.desel;
    status;
    chk({s[7:1], locked}, 8'h00);
    wen;
    status;
    chk(s, 8'h02);
    hdr(8'h9b, 24'h00_0000);
    host.xfer(4, 8'ha5, rx);
    host.desel;
    status;
    chk({s[7:1], locked}, 8'h00);
    wen;
    hdr(8'h9b, 24'h00_0000);
    host.desel;
    status;
    chk({s[7:1], locked}, 8'h00);
    wen;
    a = $urandom;
    a[5:0] = 6'h3e;
    hdr(8'h9b, a);
    for (i = 0; i < 3; i = i + 1) begin
      d[i] = $urandom;
      send(d[i]);
    end
    host.desel;
    mem[6'h3e] = d[0];
    mem[6'h3f] = d[1];
    mem[6'h00] = d[2];
    status;
    chk(s, 8'h01);
    wen;
    // polling instead of waiting out the full program time
    for (i = 0; i < 10 && s[0] !== 1'b0; i = i + 1) status;
    chk(s, 8'h00);
    chk({7'h00, locked}, 8'h01);
    read_chk({$urandom, 7'h3e}, 5);
    wen;
    hdr(8'h9b, 24'h00_0000);
    send(8'h00);
    host.desel;
    status;
    chk(s, 8'h00);
    read_chk(24'h00_0000, 2);
    finish_test;
  end
endmodule
